//--- core/lpc_pkg.sv
package lpc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SLEW = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IF = 8'h14;

    // ****************************************
    // field positions
    // ****************************************
    localparam int B_RXD = 0;
    localparam int B_DDR = 1;
    localparam int B_PUE = 0;
    localparam int B_WUE = 1;
    localparam int B_RXO = 2;
    localparam int B_EN = 3;
    localparam int B_SRC = 4;
    localparam int B_TDIS = 7;
    localparam int B_DT = 7;
    localparam int B_OC = 6;

    // ****************************************
    // slew codes and reset values
    // ****************************************
    localparam logic [1:0] SLEW_20K = 2'h0;
    localparam logic [1:0] SLEW_10K = 2'h1;
    localparam logic [1:0] SLEW_FAST = 2'h2;
    localparam logic [1:0] SLEW_RSVD = 2'h3;
    localparam logic [1:0] SLEW_RST = SLEW_20K;
    localparam logic RESP_OKAY_B = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 20;
    localparam int DT_LIMIT_US = 600;
    localparam int DT_CYC = (DT_LIMIT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int OC_MASK_NS = 1500;
    localparam int OC_MASK_CYC = (OC_MASK_NS + CLK_NS - 1) / CLK_NS;
    localparam int IRC_NS = 1000;
    localparam int REARM_BUS_CYC = 2;
    localparam int REARM_CYC = (IRC_NS + CLK_NS - 1) / CLK_NS + REARM_BUS_CYC;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_NORMAL = 2'h1,
        MODE_RECEIVE_ONLY_CTL = 2'h3,
        MODE_STANDBY = 2'h2
    } lpc_mode_e;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } lpc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lpc_axi_rsp_s;

endpackage

//--- core/lpc_timer.sv
`timescale 1ns/10ps
module lpc_timer import lpc_pkg::*; #(
    parameter int LIMIT = 4,
    parameter int W = $clog2(LIMIT + 1)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // control
    input wire logic run,
    output logic done
);
    localparam logic [W-1:0] LIM = W'(LIMIT);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } lpc_tmr_state_s;

    lpc_tmr_state_s q, d;

    // ****************************************
    // count while run, done at limit
    // ****************************************
    always_comb begin
        d = q;
        if (!run) begin
            d.cnt = '0;
            d.done = 1'b0;
        end else begin
            if (q.cnt != LIM) begin
                d.cnt = q.cnt + W'(1);
            end
            d.done = (d.cnt == LIM);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign done = q.done;

endmodule // lpc_timer

//--- core/lpc_flag.sv
`timescale 1ns/10ps
module lpc_flag import lpc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // set and clear
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    typedef struct packed {
        logic flag;
    } lpc_flag_state_s;

    lpc_flag_state_s q, d;

    // ****************************************
    // sticky flag, set beats clear
    // ****************************************
    always_comb begin
        d = q;
        d.flag = set | (q.flag & ~clr);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign flag = q.flag;

endmodule // lpc_flag

//--- core/lpc_top.sv
// Summary of operation
// - status register reads anytime; writes to it are ignored.
// - status bit 7 shows transmit input still dominant after a timeout.
// - while still dominant after timeout, transmitter stays off, flag re-sets.
// - timeout flag with enable bit 7 raises the interrupt request.
// - overcurrent flag with enable bit 6 raises the interrupt request.
// - writing one clears a flag; writing zero leaves it.
// - transmit low a timeout after falling edge sets flag 7, disables driver.
// - still dominant after clearing timeout flag keeps driver off, flag re-sets.
// - overcurrent sets flag 6 and disables the transmitter.
// - overcurrent or dominant input at clear keeps driver off, flag re-sets.
// - transmit drive comes from serial interface or a data register bit.
// - two-bit slew select resets to the 20 kbit/s setting.
// - timeout disable bit suppresses the dominant timeout.
// - overcurrent inside the masking window is neither reported nor shuts down.
// - shutdown disables everything, no timeout monitoring, registers stay reachable.
// - enable leaves shutdown into receive-only or normal mode.
// - clearing enable returns to shutdown.
// - normal mode enables receiver and transmitter; pullup select picks pullup.
// - receive-only control moves normal mode to receive-only.
// - controller stop moves normal mode to standby.
// - slew codes: 00 normal, 01 slow, 10 fast, 11 reserved.
// - receive-only disables the transmitter at once.
// - leaving stop returns to normal or receive-only per control.
// - enabled sources combine into one interrupt request line.
`timescale 1ns/10ps
module lpc_top import lpc_pkg::*; #(
    parameter int DT_LIMIT = DT_CYC,
    parameter int OC_MASK = OC_MASK_CYC,
    parameter int REARM = REARM_CYC
) (
    // clock, reset, enable
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    // register bus
    input wire lpc_axi_req_s AXI_REQ,
    output lpc_axi_rsp_s AXI_RSP,
    // transmit source and analog status
    input wire logic TXD_SCI,
    input wire logic OVERCURRENT,
    input wire logic MCU_STOP,
    // bus pin
    input wire logic LIN_I,
    output logic LIN_O,
    output logic LIN_OE_N,
    // receive and analog controls
    output logic RXD_OUT,
    output logic TX_ENABLE,
    output logic RX_ENABLE,
    output logic RX_LOW_POWER,
    output logic PULLUP_STRONG,
    output logic WAKE_ENABLE,
    output logic [1:0] SLEW_SEL,
    // interrupt
    output logic IRQ
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        lpc_mode_e mode;
        logic en;
        logic rxo;
        logic wue;
        logic pue;
        logic src;
        logic ddr;
        logic tdis;
        logic [1:0] slew;
        logic ie_dt;
        logic ie_oc;
        logic dt_hold;
        logic oc_hold;
        logic aw_ok;
        logic [ADDR_W-1:0] aw_addr;
        logic w_ok;
        logic [7:0] w_data;
        logic w_strb;
        lpc_axi_rsp_s rsp;
        logic tx_en;
        logic lin_oe_n;
        logic rxd;
        logic rx_en;
        logic rx_lp;
        logic pull;
        logic wake;
        logic [1:0] slew_out;
        logic irq;
    } lpc_top_state_s;

    lpc_top_state_s q, d;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFS_DRIVE) || (a == OFS_CTRL) || (a == OFS_SLEW) ||
            (a == OFS_STAT) || (a == OFS_IE) || (a == OFS_IF);
    endfunction

    function automatic logic [1:0] slew_decode(input logic [1:0] s);
        case (s)
            SLEW_20K: slew_decode = SLEW_20K;
            SLEW_10K: slew_decode = SLEW_10K;
            SLEW_FAST: slew_decode = SLEW_FAST;
            default: slew_decode = SLEW_20K;
        endcase
    endfunction

    // ****************************************
    // flags and timers
    // ****************************************
    logic dt_flag;
    logic oc_flag;
    logic dt_done;
    logic dt_re_done;
    logic win_done;
    logic oc_re_done;
    logic dt_clr;
    logic oc_clr;
    logic do_wr;
    logic tx_in;
    logic tx_low;
    logic normal;
    logic tx_ok;
    logic oc_evt;
    logic dt_run;
    logic dt_re_run;
    logic oc_re_run;

    assign tx_in = q.src ? q.ddr : TXD_SCI;
    assign tx_low = ~tx_in;
    assign normal = (q.mode == MODE_NORMAL);
    assign tx_ok = normal & ~dt_flag & ~oc_flag & ~q.dt_hold & ~q.oc_hold;
    assign dt_run = tx_ok & tx_low & ~q.tdis;
    assign dt_re_run = normal & ~dt_flag & q.dt_hold;
    assign oc_evt = OVERCURRENT & tx_ok & tx_low & win_done;
    assign oc_re_run = normal & ~oc_flag & q.oc_hold & (OVERCURRENT | tx_low);
    assign do_wr = q.aw_ok & q.w_ok & ~q.rsp.bvalid;
    assign dt_clr = do_wr & q.w_strb & (q.aw_addr == OFS_IF) & q.w_data[B_DT];
    assign oc_clr = do_wr & q.w_strb & (q.aw_addr == OFS_IF) & q.w_data[B_OC];

    lpc_timer #(.LIMIT(DT_LIMIT)) u_dt_tmr (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .run(dt_run),
        .done(dt_done)
    );

    lpc_timer #(.LIMIT(REARM)) u_dt_rearm (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .run(dt_re_run),
        .done(dt_re_done)
    );

    lpc_timer #(.LIMIT(OC_MASK)) u_oc_win (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .run(tx_low & normal),
        .done(win_done)
    );

    lpc_timer #(.LIMIT(REARM)) u_oc_rearm (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .run(oc_re_run),
        .done(oc_re_done)
    );

    lpc_flag u_dt_flag (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .set(dt_done | dt_re_done),
        .clr(dt_clr),
        .flag(dt_flag)
    );

    lpc_flag u_oc_flag (
        .clk(CLOCK),
        .rst(RST),
        .ce(CE),
        .set(oc_evt | oc_re_done),
        .clr(oc_clr),
        .flag(oc_flag)
    );

    // ****************************************
    // read data
    // ****************************************
    function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a,
                                            input lpc_top_state_s s,
                                            input logic fdt,
                                            input logic foc);
        rd_word = 32'h0;
        case (a)
            OFS_DRIVE: begin
                rd_word[B_DDR] = s.ddr;
                rd_word[B_RXD] = s.rxd;
            end
            OFS_CTRL: begin
                rd_word[B_SRC] = s.src;
                rd_word[B_EN] = s.en;
                rd_word[B_RXO] = s.rxo;
                rd_word[B_WUE] = s.wue;
                rd_word[B_PUE] = s.pue;
            end
            OFS_SLEW: begin
                rd_word[B_TDIS] = s.tdis;
                rd_word[1:0] = s.slew;
            end
            OFS_STAT: rd_word[B_DT] = s.dt_hold;
            OFS_IE: begin
                rd_word[B_DT] = s.ie_dt;
                rd_word[B_OC] = s.ie_oc;
            end
            OFS_IF: begin
                rd_word[B_DT] = fdt;
                rd_word[B_OC] = foc;
            end
            default: rd_word = 32'h0;
        endcase
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        // write address and data, either order
        if (AXI_REQ.awvalid && q.rsp.awready) begin
            d.aw_ok = 1'b1;
            d.aw_addr = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && q.rsp.wready) begin
            d.w_ok = 1'b1;
            d.w_data = AXI_REQ.wdata[7:0];
            d.w_strb = AXI_REQ.wstrb[0];
        end
        if (q.rsp.bvalid && AXI_REQ.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (do_wr) begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (q.w_strb) begin
                case (q.aw_addr)
                    OFS_DRIVE: d.ddr = q.w_data[B_DDR];
                    OFS_CTRL: begin
                        d.src = q.w_data[B_SRC];
                        d.en = q.w_data[B_EN];
                        d.rxo = q.w_data[B_RXO];
                        d.wue = q.w_data[B_WUE];
                        d.pue = q.w_data[B_PUE];
                    end
                    OFS_SLEW: begin
                        if (!q.en) begin
                            d.tdis = q.w_data[B_TDIS];
                            d.slew = q.w_data[1:0];
                        end
                    end
                    OFS_IE: begin
                        d.ie_dt = q.w_data[B_DT];
                        d.ie_oc = q.w_data[B_OC];
                    end
                    default: d.en = q.en;
                endcase
            end
        end
        d.rsp.awready = ~d.aw_ok;
        d.rsp.wready = ~d.w_ok;
        // read channel
        if (q.rsp.rvalid && AXI_REQ.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (AXI_REQ.arvalid && q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata = rd_word(AXI_REQ.araddr, q, dt_flag, oc_flag);
            d.rsp.rresp = mapped(AXI_REQ.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        d.rsp.arready = ~d.rsp.rvalid;
        // mode machine
        case (q.mode)
            MODE_OFF: begin
                if (q.en) begin
                    d.mode = q.rxo ? MODE_RECEIVE_ONLY_CTL : MODE_NORMAL;
                end
            end
            MODE_NORMAL: begin
                if (!q.en) begin
                    d.mode = MODE_OFF;
                end else if (MCU_STOP) begin
                    d.mode = MODE_STANDBY;
                end else if (q.rxo) begin
                    d.mode = MODE_RECEIVE_ONLY_CTL;
                end
            end
            MODE_RECEIVE_ONLY_CTL: begin
                if (!q.en) begin
                    d.mode = MODE_OFF;
                end else if (MCU_STOP) begin
                    d.mode = MODE_STANDBY;
                end else if (!q.rxo) begin
                    d.mode = MODE_NORMAL;
                end
            end
            MODE_STANDBY: begin
                if (!q.en) begin
                    d.mode = MODE_OFF;
                end else if (!MCU_STOP) begin
                    d.mode = q.rxo ? MODE_RECEIVE_ONLY_CTL : MODE_NORMAL;
                end
            end
            default: d.mode = MODE_OFF;
        endcase
        // fault holds
        d.dt_hold = dt_done | (q.dt_hold & tx_low & normal);
        d.oc_hold = oc_evt | (q.oc_hold & (OVERCURRENT | (normal & tx_low)));
        // pin and analog outputs
        d.tx_en = tx_ok & ~dt_done & ~oc_evt;
        d.lin_oe_n = ~(d.tx_en & tx_low);
        d.rxd = LIN_I;
        d.rx_en = (q.mode != MODE_OFF);
        d.rx_lp = (q.mode == MODE_STANDBY);
        d.wake = (q.mode == MODE_STANDBY) & q.wue;
        case (q.mode)
            MODE_NORMAL: d.pull = q.pue;
            MODE_RECEIVE_ONLY_CTL: d.pull = q.pue;
            MODE_STANDBY: d.pull = q.pue & q.wue;
            default: d.pull = 1'b0;
        endcase
        d.slew_out = slew_decode(q.slew);
        d.irq = (dt_flag & q.ie_dt) | (oc_flag & q.ie_oc);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            q <= '0;
            q.mode <= MODE_OFF;
            q.slew <= SLEW_RST;
            q.slew_out <= SLEW_RST;
            q.lin_oe_n <= 1'b1;
            q.rsp.awready <= 1'b1;
            q.rsp.wready <= 1'b1;
            q.rsp.arready <= 1'b1;
        end else if (CE) begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign AXI_RSP = q.rsp;
    assign LIN_O = 1'b0;
    assign LIN_OE_N = q.lin_oe_n;
    assign RXD_OUT = q.rxd;
    assign TX_ENABLE = q.tx_en;
    assign RX_ENABLE = q.rx_en;
    assign RX_LOW_POWER = q.rx_lp;
    assign PULLUP_STRONG = q.pull;
    assign WAKE_ENABLE = q.wake;
    assign SLEW_SEL = q.slew_out;
    assign IRQ = q.irq;

endmodule // lpc_top

//--- test/lpc_lin_node.sv
`timescale 1ns/10ps
module lpc_lin_node (
    // device side
    input wire logic dev_o,
    input wire logic dev_oe_n,
    // far node pull and bus level
    input wire logic pull,
    output logic bus
);
    // wired-and with pullup, idle recessive
    assign bus = (dev_oe_n | dev_o) & ~pull;
endmodule // lpc_lin_node

//--- test/lpc_top_asserts.sv
`timescale 1ns/10ps
module lpc_top_asserts import lpc_pkg::*; (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CE,
    // register bus
    input wire lpc_axi_req_s AXI_REQ,
    input wire lpc_axi_rsp_s AXI_RSP,
    // pins and status
    input wire logic MCU_STOP,
    input wire logic LIN_I,
    input wire logic LIN_OE_N,
    input wire logic RXD_OUT,
    input wire logic TX_ENABLE,
    input wire logic RX_ENABLE,
    input wire logic RX_LOW_POWER,
    input wire logic WAKE_ENABLE,
    input wire logic [1:0] SLEW_SEL,
    input wire logic IRQ
);
    // ****************
    // enable tracking
    // ****************
    typedef struct packed {
        logic [7:0] awa;
        logic [7:0] wd;
        logic [1:0] ie;
    } lpc_chk_s;
    lpc_chk_s c_q;
    lpc_chk_s c_d;
    always_comb begin
        c_d = c_q;
        if (AXI_REQ.awvalid && AXI_RSP.awready) c_d.awa = AXI_REQ.awaddr;
        if (AXI_REQ.wvalid && AXI_RSP.wready) c_d.wd = AXI_REQ.wdata[7:0];
        if (AXI_RSP.bvalid && AXI_REQ.bready && c_q.awa == OFS_IE) c_d.ie = c_q.wd[7:6];
    end
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) c_q <= '0;
        else c_q <= c_d;
    end
    // ****************
    // properties
    // ****************
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    a_rd_answer: assert property (
        AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
        else $error("read answer late");
    a_rd_done: assert property (
        AXI_RSP.rvalid && AXI_REQ.rready |=> !AXI_RSP.rvalid && AXI_RSP.arready)
        else $error("read not closed");
    a_wr_answer: assert property (
        AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready
        |-> ##2 AXI_RSP.bvalid) else $error("write answer late");
    a_rx_follow: assert property (
        !$past(RST) && $past(CE) |-> RXD_OUT == $past(LIN_I))
        else $error("receive level wrong");
    a_slew_lock: assert property (
        !$stable(SLEW_SEL) |-> !RX_ENABLE) else $error("slew changed while enabled");
    a_slew_code: assert property (
        1'b1 |-> SLEW_SEL != SLEW_RSVD) else $error("reserved slew driven");
    a_shut_quiet: assert property (
        !RX_ENABLE |-> !TX_ENABLE && !WAKE_ENABLE && !RX_LOW_POWER)
        else $error("shutdown not quiet");
    a_stby_cause: assert property (
        RX_LOW_POWER |-> !TX_ENABLE && (MCU_STOP || $past(MCU_STOP) || $past(MCU_STOP, 2)))
        else $error("standby without stop");
    a_stop_entry: assert property (
        $rose(MCU_STOP) && TX_ENABLE |-> ##[1:3] RX_LOW_POWER)
        else $error("standby not entered");
    a_oe_needs_tx: assert property (
        !LIN_OE_N |-> TX_ENABLE || $past(TX_ENABLE)) else $error("drive while disabled");
    a_irq_masked: assert property (
        c_q.ie == 2'h0 && c_d.ie == 2'h0 |=> !IRQ)
        else $error("masked interrupt raised");
endmodule // lpc_top_asserts

bind lpc_top lpc_top_asserts i_lpc_top_asserts (
    .CLOCK(CLOCK), .RST(RST), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .MCU_STOP(MCU_STOP),
    .LIN_I(LIN_I), .LIN_OE_N(LIN_OE_N), .RXD_OUT(RXD_OUT), .TX_ENABLE(TX_ENABLE),
    .RX_ENABLE(RX_ENABLE), .RX_LOW_POWER(RX_LOW_POWER), .WAKE_ENABLE(WAKE_ENABLE),
    .SLEW_SEL(SLEW_SEL), .IRQ(IRQ), .CE(CE));

//--- test/lpc_top_tb.sv
`timescale 1ns/10ps
module lpc_top_tb import lpc_pkg::*;;
    localparam int DT = 20;
    localparam int OCM = 4;
    localparam int RA = 3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    lpc_axi_req_s req = '0;
    lpc_axi_rsp_s rsp;
    logic txd = 1'b1;
    logic oc = 1'b0;
    logic stop = 1'b0;
    logic pull = 1'b0;
    logic lin_i, lin_o, oe_n, rxd, tx_en, rx_en, lp, pu, wake, irq;
    logic [1:0] slew;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    int err_total = 0;
    int cmp_count = 0;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
        logic [1:0] s;
    } lpc_row_s;
    lpc_row_s rows [7] = '{
        '{OFS_SLEW, 32'h1, 32'h1, RESP_OKAY, SLEW_10K},
        '{OFS_SLEW, 32'h2, 32'h2, RESP_OKAY, SLEW_FAST},
        '{OFS_SLEW, 32'h3, 32'h3, RESP_OKAY, SLEW_20K},
        '{OFS_SLEW, 32'h0, 32'h0, RESP_OKAY, SLEW_20K},
        '{OFS_STAT, 32'hFF, 32'h0, RESP_OKAY, SLEW_20K},
        '{OFS_IE, 32'hC0, 32'hC0, RESP_OKAY, SLEW_20K},
        '{8'h18, 32'h55, 32'h0, RESP_SLVERR, SLEW_20K}};

    lpc_top #(.DT_LIMIT(DT), .OC_MASK(OCM), .REARM(RA)) i_lpc_top (
        .CLOCK(clk), .RST(rst), .CE(ce), .AXI_REQ(req), .AXI_RSP(rsp), .TXD_SCI(txd),
        .OVERCURRENT(oc), .MCU_STOP(stop), .LIN_I(lin_i), .LIN_O(lin_o), .LIN_OE_N(oe_n),
        .RXD_OUT(rxd), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .RX_LOW_POWER(lp),
        .PULLUP_STRONG(pu), .WAKE_ENABLE(wake), .SLEW_SEL(slew), .IRQ(irq));
    lpc_lin_node i_lpc_lin_node (.dev_o(lin_o), .dev_oe_n(oe_n), .pull(pull), .bus(lin_i));

    // ****************
    // bus tasks
    // ****************
    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid && n < 50);
        bresp_q = rsp.bresp;
        req.bready <= 1'b0;
        if (n >= 50) begin
            err_total++;
            finish_test();
        end
        tick(3);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        int n;
        n = 0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid && n < 50);
        rresp_q = rsp.rresp;
        chk(nm, e, rsp.rdata);
        req.rready <= 1'b0;
        if (n >= 50) begin
            err_total++;
            finish_test();
        end
        @(posedge clk);
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        tick(100000);
        err_total++;
        finish_test();
    end
    initial begin
        int n;
        tick(5);
        rst <= 1'b0;
        tick(1);
        chk("slew_rst", SLEW_RST, slew);
        chk("oe_rst", 1'b1, oe_n);
        rc("slew_reg", OFS_SLEW, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("bresp", rows[i].r, bresp_q);
            rc("rdata", rows[i].a, rows[i].e);
            chk("rresp", rows[i].r, rresp_q);
            chk("slew", rows[i].s, slew);
        end
        wr(OFS_CTRL, 32'h9);
        chk("tx_en", 1'b1, tx_en);
        chk("pullup", 1'b1, pu);
        wr(OFS_SLEW, 32'h2);
        rc("slew_lock", OFS_SLEW, 32'h0);
        wr(OFS_DRIVE, 32'h2);
        txd <= 1'b0;
        wr(OFS_CTRL, 32'h19);
        chk("src_sci", 1'b1, oe_n);
        txd <= 1'b1;
        wr(OFS_DRIVE, 32'h0);
        chk("src_dir", 1'b0, oe_n);
        rc("drv_low", OFS_DRIVE, 32'h0);
        wr(OFS_DRIVE, 32'h2);
        pull <= 1'b1;
        tick(2);
        rc("far_pull", OFS_DRIVE, 32'h2);
        pull <= 1'b0;
        wr(OFS_CTRL, 32'h9);
        wr(OFS_IE, 32'h80);
        txd <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_en === 1'b1 && n < DT + 10);
        chk("dt_len", 1'b1, n >= DT && n <= DT + 3);
        rc("stat_dom", OFS_STAT, 32'h80);
        rc("flag_dt", OFS_IF, 32'h80);
        chk("irq_dt", 1'b1, irq);
        wr(OFS_IF, 32'h0);
        rc("flag_w0", OFS_IF, 32'h80);
        wr(OFS_IF, 32'h80);
        tick(RA + 4);
        rc("dt_rearm", OFS_IF, 32'h80);
        chk("dt_held", 1'b0, tx_en);
        txd <= 1'b1;
        tick(2);
        rc("stat_rel", OFS_STAT, 32'h0);
        wr(OFS_IF, 32'h80);
        tick(RA + 4);
        rc("dt_clr", OFS_IF, 32'h0);
        chk("irq_clr", 1'b0, irq);
        wr(OFS_IE, 32'h0);
        txd <= 1'b0;
        oc <= 1'b1;
        tick(OCM - 2);
        oc <= 1'b0;
        txd <= 1'b1;
        tick(2);
        rc("oc_mask", OFS_IF, 32'h0);
        txd <= 1'b0;
        oc <= 1'b1;
        tick(OCM + 4);
        chk("oc_tx", 1'b0, tx_en);
        chk("oc_irq_off", 1'b0, irq);
        txd <= 1'b1;
        rc("oc_flag", OFS_IF, 32'h40);
        wr(OFS_IE, 32'h40);
        chk("oc_irq", 1'b1, irq);
        wr(OFS_IF, 32'h40);
        tick(RA + 4);
        rc("oc_rearm", OFS_IF, 32'h40);
        oc <= 1'b0;
        wr(OFS_IF, 32'h40);
        tick(RA + 4);
        rc("oc_clr", OFS_IF, 32'h0);
        chk("oc_back", 1'b1, tx_en);
        wr(OFS_CTRL, 32'h0);
        chk("shut_rx", 1'b0, rx_en);
        txd <= 1'b0;
        tick(DT + 4);
        txd <= 1'b1;
        rc("shut_flag", OFS_IF, 32'h0);
        wr(OFS_SLEW, 32'h80);
        wr(OFS_CTRL, 32'h8);
        txd <= 1'b0;
        tick(DT + 10);
        chk("dis_tx", 1'b1, tx_en);
        txd <= 1'b1;
        rc("dis_flag", OFS_IF, 32'h0);
        wr(OFS_CTRL, 32'hC);
        chk("ro_tx", 1'b0, tx_en);
        wr(OFS_CTRL, 32'h8);
        txd <= 1'b0;
        tick(2);
        chk("ro_drive", 1'b0, oe_n);
        wr(OFS_CTRL, 32'hC);
        chk("ro_abort", 1'b1, oe_n);
        tick(DT);
        txd <= 1'b1;
        rc("ro_flag", OFS_IF, 32'h0);
        wr(OFS_CTRL, 32'hA);
        stop <= 1'b1;
        tick(4);
        chk("sb_wake", 1'b1, wake);
        stop <= 1'b0;
        tick(4);
        chk("sb_back", 1'b1, tx_en);
        wr(OFS_CTRL, 32'hE);
        stop <= 1'b1;
        tick(4);
        stop <= 1'b0;
        tick(4);
        chk("sb_ro", 1'b0, tx_en | lp);
        ce <= 1'b0;
        pull <= 1'b1;
        tick(3);
        chk("ce_hold", 1'b1, rxd);
        ce <= 1'b1;
        tick(2);
        chk("ce_run", 1'b0, rxd);
        pull <= 1'b0;
        finish_test();
    end
endmodule // lpc_top_tb
